// ==== pcl_loader.sv ====
/*
  program counter loader: holds the 15-bit counter, the readable low byte
  and the software-written high latch, and applies the decoder's load
  operation each cycle.
  assumes the decoder presents at most one operation per cycle, and that a
  latch write and a counter operation are sequenced by the core.
*/
// Function
// - counter is fifteen bits wide
// - low byte readable and writable
// - high bits only loaded, never accessed
// - any reset clears whole counter
// - low write reloads high from latch
// - accumulator add to low jumps
// - call loads high 2:0 and low
// - call fills high 6:3 from latch
// - accumulator call uses latch high
// - accumulator branch adds to incremented counter
// - relative branch adds signed offset
`timescale 1ns/10ps
`include "pcl_regs.svh"

module pcl_loader
  import pcl_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire pcl_op_t              i_op,
  input  wire logic [7:0]           i_wdata,
  input  wire logic [7:0]           i_accum,
  input  wire logic [10:0]          i_call_addr,
  input  wire logic [8:0]           i_rel_offset,
  input  wire logic                 i_latch_we,
  input  wire logic [7:0]           i_latch_wdata,
  output logic      [14:0]          o_pc,
  output logic      [7:0]           o_low_byte,
  output logic      [7:0]           o_latch
);
  logic [`PCL_PC_W-1:0] pc;
  logic [`PCL_PC_W-1:0] next_pc;
  logic [7:0]           latch;
  logic [7:0]           next_latch;
  logic [14:0]          target;
  logic                 load;

  // target arithmetic
  pcl_target u_target (
    .i_op         (i_op),
    .i_pc         (pc),
    .i_latch      (latch),
    .i_accum      (i_accum),
    .i_wdata      (i_wdata),
    .i_call_addr  (i_call_addr),
    .i_rel_offset (i_rel_offset),
    .o_target     (target),
    .o_load       (load)
  );

  // next counter and latch values
  always_comb begin
    next_pc    = pc;
    next_latch = latch;
    if (load) begin
      next_pc = target;
    end
    if (i_latch_we) begin
      next_latch = i_latch_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc    <= `PCL_PC_RESET;
      latch <= `PCL_LATCH_RESET;
    end else begin
      pc    <= next_pc;
      latch <= next_latch;
    end
  end

  // registered outputs
  // low byte read path
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pc       <= `PCL_PC_RESET;
      o_low_byte <= 8'h00;
      o_latch    <= `PCL_LATCH_RESET;
    end else begin
      o_pc       <= next_pc;
      o_low_byte <= next_pc[7:0];
      o_latch    <= next_latch;
    end
  end

  property p_reset_clear;
    @(posedge i_clk) $rose(i_resetn) |-> (o_pc == 15'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("counter not clear after reset");

  property p_reset_outputs;
    @(posedge i_clk) $rose(i_resetn) |-> (o_low_byte == 8'h00) && (o_latch == 8'h00);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs not clear after reset");

  property p_write_low;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_WRITE_LOW) |=> (o_pc == {$past(latch[6:0]), $past(i_wdata)});
  endproperty
  a_write_low: assert property (p_write_low)
    else $error("low write wrong target");

  property p_write_old_latch;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_latch_we && (i_op == PCL_OP_WRITE_LOW)) |=> (o_pc[14:8] == $past(o_latch[6:0]));
  endproperty
  a_write_old_latch: assert property (p_write_old_latch)
    else $error("low write took new latch");

  property p_add_low;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_ADD_LOW) |=>
        (o_pc == {$past(latch[6:0]), 8'($past(pc[7:0]) + $past(i_accum))});
  endproperty
  a_add_low: assert property (p_add_low)
    else $error("computed jump wrong");

  property p_call_low;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_CALL) |=> (o_pc[10:0] == $past(i_call_addr));
  endproperty
  a_call_low: assert property (p_call_low)
    else $error("call operand bits wrong");

  property p_call_high;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_CALL) |=> (o_pc[14:11] == $past(latch[6:3]));
  endproperty
  a_call_high: assert property (p_call_high)
    else $error("call latch bits wrong");

  property p_call_acc;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_CALL_ACC) |=> (o_pc == {$past(latch[6:0]), $past(i_accum)});
  endproperty
  a_call_acc: assert property (p_call_acc)
    else $error("accumulator call wrong");

  property p_jump_acc;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_JUMP_ACC) |=>
        (o_pc == 15'($past(pc) + 15'h0001 + {7'h00, $past(i_accum)}));
  endproperty
  a_jump_acc: assert property (p_jump_acc)
    else $error("accumulator branch wrong");

  property p_rel_jump;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_REL_JUMP) |=>
        (o_pc == 15'($past(pc) + 15'h0001 + {{6{$past(i_rel_offset[8])}}, $past(i_rel_offset)}));
  endproperty
  a_rel_jump: assert property (p_rel_jump)
    else $error("relative branch wrong");

  property p_inc;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_INC) |=> (o_pc == 15'($past(pc) + 15'h0001));
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment wrong");

  property p_inc_wrap;
    @(posedge i_clk) disable iff (!i_resetn)
      ((i_op == PCL_OP_INC) && (o_pc == 15'h7fff)) |=> (o_pc == 15'h0000);
  endproperty
  a_inc_wrap: assert property (p_inc_wrap)
    else $error("increment did not wrap");

  property p_inc_high_keep;
    @(posedge i_clk) disable iff (!i_resetn)
      ((i_op == PCL_OP_INC) && (o_pc[7:0] != 8'hff)) |=> (o_pc[14:8] == $past(o_pc[14:8]));
  endproperty
  a_inc_high_keep: assert property (p_inc_high_keep)
    else $error("high bits changed on plain increment");

  property p_latch_only;
    @(posedge i_clk) disable iff (!i_resetn)
      ((i_op == PCL_OP_NONE) && i_latch_we) |=> $stable(o_pc);
  endproperty
  a_latch_only: assert property (p_latch_only)
    else $error("latch write moved counter");

  property p_latch_write;
    @(posedge i_clk) disable iff (!i_resetn)
      i_latch_we |=> (o_latch == $past(i_latch_wdata));
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch write lost");

  property p_latch_hold;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_latch_we |=> $stable(o_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without write");

  property p_hold;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_NONE) |=> $stable(o_pc) && (o_low_byte == o_pc[7:0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without operation");

  property p_write_low_byte;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_op == PCL_OP_WRITE_LOW) |=> (o_low_byte == $past(i_wdata));
  endproperty
  a_write_low_byte: assert property (p_write_low_byte)
    else $error("written low byte not readable");

  property p_low_mirror;
    @(posedge i_clk) disable iff (!i_resetn) (o_low_byte == o_pc[7:0]);
  endproperty
  a_low_mirror: assert property (p_low_mirror)
    else $error("low byte view differs from counter");
endmodule

// ==== pcl_regs.svh ====
/*
  constants for the program counter loader: widths, field positions,
  reset values and the single-cycle update count.
  assumes inclusion by bare name from the loader files.
*/
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH

`define PCL_PC_W        15
`define PCL_LOW_W       8
`define PCL_HIGH_W      7
`define PCL_CALL_LO_MSB 10
`define PCL_CALL_HI_LSB 3
`define PCL_PC_RESET    15'h0000
`define PCL_LATCH_RESET 8'h00
`define PCL_LOAD_CYCLES 1

`endif

// ==== pcl_pkg.sv ====
/*
  types for the program counter loader: the load operation selector.
  assumes the decoder encodes one operation per fetch slot.
*/
package pcl_pkg;
  typedef enum logic [2:0] {
    PCL_OP_NONE,
    PCL_OP_INC,
    PCL_OP_WRITE_LOW,
    PCL_OP_ADD_LOW,
    PCL_OP_CALL,
    PCL_OP_CALL_ACC,
    PCL_OP_JUMP_ACC,
    PCL_OP_REL_JUMP
  } pcl_op_t;
endpackage

// ==== pcl_target.sv ====
/*
  combinational target address calculation for the program counter.
  assumes all operands are stable in the cycle the operation is presented.
*/
`timescale 1ns/10ps
`include "pcl_regs.svh"

module pcl_target
  import pcl_pkg::*;
(
  input  wire pcl_op_t              i_op,
  input  wire logic [14:0]          i_pc,
  input  wire logic [7:0]           i_latch,
  input  wire logic [7:0]           i_accum,
  input  wire logic [7:0]           i_wdata,
  input  wire logic [10:0]          i_call_addr,
  input  wire logic [8:0]           i_rel_offset,
  output logic      [14:0]          o_target,
  output logic                      o_load
);
  logic [14:0] pc_inc;
  logic [7:0]  add_sum;

  // shared incremented counter and low-byte sum
  assign pc_inc  = 15'(i_pc + 15'h0001);
  assign add_sum = 8'(i_pc[7:0] + i_accum);

  // target selection per operation
  always_comb begin
    o_target = i_pc;
    o_load   = 1'b1;
    unique case (i_op)
      PCL_OP_NONE: begin
        o_load = 1'b0;
      end
      PCL_OP_INC: begin
        o_target = pc_inc;
      end
      PCL_OP_WRITE_LOW: begin
        o_target = {i_latch[6:0], i_wdata};
      end
      PCL_OP_ADD_LOW: begin
        o_target = {i_latch[6:0], add_sum};
      end
      PCL_OP_CALL: begin
        o_target = {i_latch[6:3], i_call_addr};
      end
      PCL_OP_CALL_ACC: begin
        o_target = {i_latch[6:0], i_accum};
      end
      PCL_OP_JUMP_ACC: begin
        o_target = 15'(pc_inc + {7'h00, i_accum});
      end
      PCL_OP_REL_JUMP: begin
        o_target = 15'(pc_inc + {{6{i_rel_offset[8]}}, i_rel_offset});
      end
    endcase
  end
endmodule

// ==== pcl_acc_model.sv ====
/*
  accumulator model of the core datapath feeding the loader.
  assumes writes arrive just after a clock edge.
*/
`timescale 1ns/10ps
module pcl_acc_model (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_we,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_accum
);
  logic [7:0] next_accum;
  // load or hold
  always_comb begin
    next_accum = i_we ? i_data : o_accum;
  end
  // register, cleared on reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_accum <= 8'h00;
    end else begin
      o_accum <= next_accum;
    end
  end
endmodule

// ==== tb_program_counter_loader.sv ====
/*
  self-checking bench for the program counter loader.
  assumes one operation per cycle, with the accumulator model beside it.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_program_counter_loader
  import pcl_pkg::*;
;
  logic        i_clk    = 1'b0;
  logic        i_resetn = 1'b0;
  pcl_op_t     op       = PCL_OP_NONE;
  logic [7:0]  wdata    = 8'h00;
  logic [7:0]  acc_d    = 8'h00;
  logic [7:0]  lat_d    = 8'h00;
  logic [10:0] call_a   = 11'h000;
  logic [8:0]  rel_off  = 9'h000;
  logic        acc_we   = 1'b0;
  logic        lat_we   = 1'b0;
  logic        pend     = 1'b0;
  logic [14:0] e_pc     = 15'h0000;
  logic [7:0]  e_lat    = 8'h00;
  logic [7:0]  e_acc    = 8'h00;
  logic [22:0] note;
  logic [22:0] q[$];
  logic [14:0] pc;
  logic [7:0]  low_b, latch, accum;
  int          err_count = 0, total_checks = 0, seed = 81969, cycles = 0, r;

  pcl_acc_model u_acc (.i_clk(i_clk), .i_resetn(i_resetn), .i_we(acc_we), .i_data(acc_d),
    .o_accum(accum));
  pcl_loader dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_op(op), .i_wdata(wdata),
    .i_accum(accum), .i_call_addr(call_a), .i_rel_offset(rel_off), .i_latch_we(lat_we),
    .i_latch_wdata(lat_d), .o_pc(pc), .o_low_byte(low_b), .o_latch(latch));

  // clock and cycle limit
  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one operation: drive it and note the expected result
  task automatic step(input pcl_op_t o, input logic [31:0] v);
    logic [14:0] n;
    @(posedge i_clk);
    #1;
    op = o;
    wdata = v[7:0];
    call_a = v[18:8];
    rel_off = v[27:19];
    acc_we = v[28];
    acc_d = v[15:8];
    lat_we = v[29];
    lat_d = v[31:24];
    case (o)
      PCL_OP_INC:       n = e_pc + 15'h0001;
      PCL_OP_WRITE_LOW: n = {e_lat[6:0], v[7:0]};
      PCL_OP_ADD_LOW:   n = {e_lat[6:0], e_pc[7:0] + e_acc};
      PCL_OP_CALL:      n = {e_lat[6:3], v[18:8]};
      PCL_OP_CALL_ACC:  n = {e_lat[6:0], e_acc};
      PCL_OP_JUMP_ACC:  n = e_pc + 15'h0001 + {7'h00, e_acc};
      PCL_OP_REL_JUMP:  n = e_pc + 15'h0001 + {{6{v[27]}}, v[27:19]};
      default:          n = e_pc;
    endcase
    e_pc = n;
    if (v[29]) e_lat = v[31:24];
    if (v[28]) e_acc = v[15:8];
    q.push_back({e_pc, e_lat});
    pend = 1'b1;
  endtask

  // stop noting, reset for eight cycles, check cleared outputs
  task automatic do_reset();
    @(posedge i_clk);
    #1;
    pend = 1'b0;
    op = PCL_OP_NONE;
    acc_we = 1'b0;
    lat_we = 1'b0;
    // let the last noted result be checked before outputs clear
    if (i_resetn) begin
      @(posedge i_clk);
      #1;
    end
    i_resetn = 1'b0;
    repeat (8) @(posedge i_clk);
    `CHK({pc, latch}, 23'h000000)
    `CHK(low_b, 8'h00)
    #1 i_resetn = 1'b1;
    e_pc = 15'h0000;
    e_lat = 8'h00;
    e_acc = 8'h00;
  endtask

  // compare outputs with the oldest note
  always @(posedge i_clk) begin
    if (pend) begin
      #2;
      note = q.pop_front();
      `CHK(pc, note[22:8])
      `CHK(low_b, note[15:8])
      `CHK(latch, note[7:0])
    end
  end

  // every op, wrap both ways, random traffic, reset mid-run
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) step(pcl_op_t'(i[2:0]), $random(seed));
    step(PCL_OP_NONE, 32'h7f000000);
    step(PCL_OP_WRITE_LOW, 32'h000000ff);
    step(PCL_OP_INC, 32'h00000000);
    step(PCL_OP_REL_JUMP, 32'h0ff00000);
    repeat (300) begin
      r = $random(seed);
      step(pcl_op_t'(r[2:0]), $random(seed));
    end
    do_reset();
    repeat (100) begin
      r = $random(seed);
      step(pcl_op_t'(r[2:0]), $random(seed));
    end
    @(posedge i_clk);
    #1 pend = 1'b0;
    #5 end_sim();
  end
endmodule
